// ---- design/hm_dog_cond.sv ----
// Proximity dog polarity and edge detection
`timescale 1ns/1ps
`default_nettype none
module hm_dog_cond (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic dog_in,
    input wire logic dog_polarity_param,
    output var logic dog_active,
    output var logic dog_front,
    output var logic dog_rear
);
    import hm_pkg::*;
    logic act_reg, act_next, front_reg, front_next, rear_reg, rear_next;
    always_comb
    begin
        act_next = dog_in ~^ dog_polarity_param;
        front_next = act_next & ~act_reg;
        rear_next = ~act_next & act_reg;
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            act_reg <= 1'b0;
            front_reg <= 1'b0;
            rear_reg <= 1'b0;
        end
        else
        begin
            act_reg <= act_next;
            front_reg <= front_next;
            rear_reg <= rear_next;
        end
    end
    assign dog_active = act_reg;
    assign dog_front = front_reg;
    assign dog_rear = rear_reg;
endmodule : hm_dog_cond
`default_nettype wire

// ---- design/hm_homing.sv ----
// Manual homing sequencer with Avalon-MM register slave
//
// Design decisions made here: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module hm_homing #(
    parameter int POS_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [hm_pkg::AVS_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [hm_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output var logic [hm_pkg::DATA_W-1:0] avs_readdata,
    output var logic avs_waitrequest,
    input wire logic dog_in,
    input wire logic enc_index,
    input wire logic enc_step,
    input wire logic enc_dir,
    output var logic motion_enable,
    output var logic move_dir,
    output var logic [hm_pkg::DATA_W-1:0] speed_cmd,
    output var logic [hm_pkg::TIME_W-1:0] accel_time,
    output var logic [hm_pkg::TIME_W-1:0] decel_time,
    output var logic home_done,
    output var logic [POS_W-1:0] cur_pos
);
    import hm_pkg::*;

    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (be[i])
                r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction : be_merge

    logic wait_reg, wait_next;
    logic [31:0] rdata_reg, rdata_next;
    logic auto_manual_select_bit_reg, auto_manual_select_bit_next;
    logic [TBL_W-1:0] table_select_reg, table_select_next;
    logic pos_speed_source_select_reg, pos_speed_source_select_next;
    logic [31:0] homing_method_param_reg, homing_method_param_next;
    logic homing_direction_param_reg, homing_direction_param_next;
    logic dog_polarity_param_reg, dog_polarity_param_next;
    logic [31:0] homing_fast_speed_param_reg, homing_fast_speed_param_next;
    logic [31:0] creep_speed_param_reg, creep_speed_param_next;
    logic [31:0] home_shift_distance_param_reg, home_shift_distance_param_next;
    logic [31:0] home_position_value_param_reg, home_position_value_param_next;
    logic [31:0] accdec_reg, accdec_next;
    hm_state_type state_reg, state_next;
    logic dir_reg, dir_next, en_reg, en_next, done_reg, done_next, err_reg, err_next;
    logic [31:0] speed_reg, speed_next;
    logic idx_prev_reg;
    logic wr_take, rd_cap, start_req, start_ok, abort, idx_rise, load_home, trav_clr;
    logic [31:0] ctrl_img, dirpol_img, status_img, wr_old;
    logic dog_active, dog_front, dog_rear;
    logic [POS_W-1:0] travel, pos_now;
    logic [3:0] meth;

    hm_dog_cond u_dog (
        .ref_clk(ref_clk),
        .rst(rst),
        .dog_in(dog_in),
        .dog_polarity_param(dog_polarity_param_reg),
        .dog_active(dog_active),
        .dog_front(dog_front),
        .dog_rear(dog_rear)
    );

    hm_pos_track #(.POS_W(POS_W)) u_pos (
        .ref_clk(ref_clk),
        .rst(rst),
        .enc_step(enc_step),
        .enc_dir(enc_dir),
        .load(load_home),
        .load_value(home_position_value_param_reg[POS_W-1:0]),
        .travel_clr(trav_clr),
        .cur_pos(pos_now),
        .travel(travel)
    );

    assign meth = homing_method_param_reg[3:0];
    assign idx_rise = enc_index & ~idx_prev_reg;
    assign wr_take = avs_write & ~wait_reg;
    assign rd_cap = avs_read & wait_reg;
    assign ctrl_img = {21'h0, pos_speed_source_select_reg, table_select_reg, auto_manual_select_bit_reg, 1'b0};
    assign dirpol_img = {30'h0, dog_polarity_param_reg, homing_direction_param_reg};
    assign status_img = {25'h0, state_reg, 1'b0, err_reg, done_reg, en_reg};

    // Bus slave: one wait cycle, then answer
    always_comb
    begin
        wait_next = ~((avs_read | avs_write) & wait_reg);
        rdata_next = rdata_reg;
        if (rd_cap)
        begin
            case (avs_address)
                OFS_CTRL: rdata_next = ctrl_img;
                OFS_METHOD: rdata_next = homing_method_param_reg;
                OFS_DIRPOL: rdata_next = dirpol_img;
                OFS_FAST: rdata_next = homing_fast_speed_param_reg;
                OFS_CREEP: rdata_next = creep_speed_param_reg;
                OFS_SHIFT: rdata_next = home_shift_distance_param_reg;
                OFS_HOME: rdata_next = home_position_value_param_reg;
                OFS_ACCDEC: rdata_next = accdec_reg;
                OFS_STATUS: rdata_next = status_img;
                OFS_POS: rdata_next = 32'(pos_now);
                default: rdata_next = RST_WORD;
            endcase
        end
    end

    // Register writes
    always_comb
    begin
        auto_manual_select_bit_next = auto_manual_select_bit_reg;
        table_select_next = table_select_reg;
        pos_speed_source_select_next = pos_speed_source_select_reg;
        homing_method_param_next = homing_method_param_reg;
        homing_direction_param_next = homing_direction_param_reg;
        dog_polarity_param_next = dog_polarity_param_reg;
        homing_fast_speed_param_next = homing_fast_speed_param_reg;
        creep_speed_param_next = creep_speed_param_reg;
        home_shift_distance_param_next = home_shift_distance_param_reg;
        home_position_value_param_next = home_position_value_param_reg;
        accdec_next = accdec_reg;
        start_req = 1'b0;
        wr_old = RST_WORD;
        if (wr_take)
        begin
            case (avs_address)
                OFS_CTRL:
                begin
                    wr_old = be_merge(ctrl_img, avs_writedata, avs_byteenable);
                    start_req = wr_old[CTRL_START];
                    auto_manual_select_bit_next = wr_old[CTRL_AUTO_MAN];
                    table_select_next = wr_old[CTRL_TBL_LSB +: TBL_W];
                    pos_speed_source_select_next = wr_old[CTRL_SRC];
                end
                OFS_METHOD: homing_method_param_next = be_merge(homing_method_param_reg, avs_writedata, avs_byteenable);
                OFS_DIRPOL:
                begin
                    wr_old = be_merge(dirpol_img, avs_writedata, avs_byteenable);
                    homing_direction_param_next = wr_old[DIRPOL_DIR];
                    dog_polarity_param_next = wr_old[DIRPOL_POL];
                end
                OFS_FAST: homing_fast_speed_param_next = be_merge(homing_fast_speed_param_reg, avs_writedata, avs_byteenable);
                OFS_CREEP: creep_speed_param_next = be_merge(creep_speed_param_reg, avs_writedata, avs_byteenable);
                OFS_SHIFT: home_shift_distance_param_next = be_merge(home_shift_distance_param_reg, avs_writedata, avs_byteenable);
                OFS_HOME: home_position_value_param_next = be_merge(home_position_value_param_reg, avs_writedata, avs_byteenable);
                OFS_ACCDEC: accdec_next = be_merge(accdec_reg, avs_writedata, avs_byteenable);
                default: start_req = 1'b0;
            endcase
        end
    end

    // Manual mode only with all table bits off
    assign start_ok = start_req & auto_manual_select_bit_next & (table_select_next == '0)
        & (state_reg == S_IDLE);
    assign abort = (state_reg != S_IDLE) & ~auto_manual_select_bit_next;

    // Homing sequence
    always_comb
    begin
        state_next = state_reg;
        dir_next = dir_reg;
        done_next = done_reg;
        err_next = err_reg;
        load_home = 1'b0;
        trav_clr = 1'b0;
        case (state_reg)
            S_IDLE:
            begin
                if (start_ok)
                begin
                    done_next = 1'b0;
                    if (meth == METH_CRADLE || meth == METH_FIRST_IDX || meth == METH_FRONT || meth == METH_DOGLESS)
                    begin
                        err_next = 1'b0;
                        state_next = S_FAST;
                        dir_next = homing_direction_param_reg;
                    end
                    else
                        err_next = 1'b1;
                end
                else if (start_req)
                    err_next = 1'b1;
            end
            S_FAST:
            begin
                if (meth == METH_DOGLESS)
                begin
                    if (idx_rise)
                    begin
                        state_next = S_SHIFT;
                        trav_clr = 1'b1;
                    end
                end
                else if (dog_front)
                begin
                    case (meth)
                        METH_CRADLE: state_next = S_CREEP;
                        METH_FIRST_IDX:
                        begin
                            state_next = S_LEAVE;
                            dir_next = ~dir_reg;
                        end
                        default:
                        begin
                            state_next = S_SHIFT;
                            trav_clr = 1'b1;
                        end
                    endcase
                end
            end
            S_LEAVE:
                if (dog_rear)
                    state_next = S_CREEP;
            S_CREEP:
                if (idx_rise)
                begin
                    state_next = S_SHIFT;
                    trav_clr = 1'b1;
                end
            S_SHIFT:
                if (travel >= home_shift_distance_param_reg[POS_W-1:0])
                begin
                    state_next = S_IDLE;
                    done_next = 1'b1;
                    load_home = 1'b1;
                end
            default: state_next = S_IDLE;
        endcase
        if (abort)
        begin
            state_next = S_IDLE;
            err_next = 1'b1;
            load_home = 1'b0;
        end
        en_next = (state_next != S_IDLE);
        // Fast speed until the dog is seen, or until the index pulse when dogless, creep after it
        speed_next = (state_next == S_FAST) ? homing_fast_speed_param_reg : creep_speed_param_reg;
        if (state_next == S_IDLE)
            speed_next = RST_WORD;
    end

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            wait_reg <= 1'b1;
            rdata_reg <= RST_WORD;
            auto_manual_select_bit_reg <= 1'b0;
            table_select_reg <= '0;
            pos_speed_source_select_reg <= 1'b0;
            homing_method_param_reg <= RST_WORD;
            homing_direction_param_reg <= 1'b0;
            dog_polarity_param_reg <= 1'b0;
            homing_fast_speed_param_reg <= RST_WORD;
            creep_speed_param_reg <= RST_WORD;
            home_shift_distance_param_reg <= RST_WORD;
            home_position_value_param_reg <= RST_WORD;
            accdec_reg <= RST_WORD;
            state_reg <= S_IDLE;
            dir_reg <= 1'b0;
            en_reg <= 1'b0;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            speed_reg <= RST_WORD;
            idx_prev_reg <= 1'b0;
        end
        else
        begin
            wait_reg <= wait_next;
            rdata_reg <= rdata_next;
            auto_manual_select_bit_reg <= auto_manual_select_bit_next;
            table_select_reg <= table_select_next;
            pos_speed_source_select_reg <= pos_speed_source_select_next;
            homing_method_param_reg <= homing_method_param_next;
            homing_direction_param_reg <= homing_direction_param_next;
            dog_polarity_param_reg <= dog_polarity_param_next;
            homing_fast_speed_param_reg <= homing_fast_speed_param_next;
            creep_speed_param_reg <= creep_speed_param_next;
            home_shift_distance_param_reg <= home_shift_distance_param_next;
            home_position_value_param_reg <= home_position_value_param_next;
            accdec_reg <= accdec_next;
            state_reg <= state_next;
            dir_reg <= dir_next;
            en_reg <= en_next;
            done_reg <= done_next;
            err_reg <= err_next;
            speed_reg <= speed_next;
            idx_prev_reg <= enc_index;
        end
    end

    assign avs_waitrequest = wait_reg;
    assign avs_readdata = rdata_reg;
    assign motion_enable = en_reg;
    assign move_dir = dir_reg;
    assign speed_cmd = speed_reg;
    assign accel_time = accdec_reg[ACC_LSB +: TIME_W];
    assign decel_time = accdec_reg[DEC_LSB +: TIME_W];
    assign home_done = done_reg;
    assign cur_pos = pos_now;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence fast_front(logic [3:0] m);
        state_reg == S_FAST && meth == m && dog_front && !abort;
    endsequence
    sequence shift_end;
        state_reg == S_SHIFT && travel >= home_shift_distance_param_reg[POS_W-1:0] && !abort;
    endsequence

    AST_CRADLE_SEL: assert property (fast_front(METH_CRADLE) |=> state_reg == S_CREEP)
        else $error("cradle method did not enter creep");
    AST_CRADLE_IDX: assert property (state_reg == S_CREEP && idx_rise && !abort |=> state_reg == S_SHIFT)
        else $error("index pulse did not fix home");
    AST_FIRST_REV: assert property (fast_front(METH_FIRST_IDX) ##1 !wr_take |-> state_reg == S_LEAVE
        && dir_reg != $past(dir_reg) && speed_cmd == creep_speed_param_reg)
        else $error("no reverse at creep after dog front");
    AST_LEAVE_IDX: assert property (state_reg == S_LEAVE && dog_rear && !abort |=> state_reg == S_CREEP)
        else $error("leaving dog did not arm index search");
    AST_FRONT_HOME: assert property (fast_front(METH_FRONT) |=> state_reg == S_SHIFT)
        else $error("front end did not become reference");
    AST_DOGLESS: assert property (state_reg == S_FAST && meth == METH_DOGLESS && idx_rise && !abort
        |=> state_reg == S_SHIFT && travel == '0)
        else $error("dogless index not taken");
    AST_FAST_SPEED: assert property (state_reg == S_FAST ##1 state_reg == S_FAST && !$past(wr_take)
        |-> speed_cmd == homing_fast_speed_param_reg)
        else $error("fast speed not applied");
    AST_LOAD_HOME: assert property (shift_end |=> home_done && cur_pos == $past(home_position_value_param_reg[POS_W-1:0])
        && !motion_enable)
        else $error("home value not loaded on completion");
    AST_START_DIR: assert property (start_ok && meth == METH_CRADLE |=> motion_enable
        && move_dir == $past(homing_direction_param_reg) ##1 speed_cmd != RST_WORD || state_reg != S_FAST)
        else $error("start direction wrong");
endmodule : hm_homing
`default_nettype wire

// ---- design/hm_pkg.sv ----
// Constants and types of the homing sequencer
// What this block does
// - Method code 7 in the lowest digit selects dog cradle homing.
// - Cradle: home is the first index pulse after the dog front end.
// - Method code 8 selects first index-pulse reference homing.
// - First index: at dog front end reverse and travel at creep speed.
// - First index: after leaving the dog, first index pulse fixes home.
// - Method code 9 selects front-end reference; dog front end becomes home.
// - Dogless: first index pulse after start is home.
// - Travel at homing speed until the dog is detected.
// - After the dog is detected, travel at creep speed.
// - Final home is offset from the reference by the shift distance.
// - Homing uses the acceleration and deceleration of point-table entry one; the code takes them from the OFS_ACCDEC register instead.
// - On completion the current position is loaded with the home value.
// - Travel starts in the direction of the homing-direction parameter.
// - Dog input active level follows the dog-polarity parameter.
package hm_pkg;
    localparam int AVS_AW = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_METHOD = 8'h04;
    localparam logic [7:0] OFS_DIRPOL = 8'h08;
    localparam logic [7:0] OFS_FAST = 8'h0c;
    localparam logic [7:0] OFS_CREEP = 8'h10;
    localparam logic [7:0] OFS_SHIFT = 8'h14;
    localparam logic [7:0] OFS_HOME = 8'h18;
    localparam logic [7:0] OFS_ACCDEC = 8'h1c;
    localparam logic [7:0] OFS_STATUS = 8'h20;
    localparam logic [7:0] OFS_POS = 8'h24;
    localparam int CTRL_START = 0;
    localparam int CTRL_AUTO_MAN = 1;
    localparam int CTRL_TBL_LSB = 2;
    localparam int TBL_W = 8;
    localparam int CTRL_SRC = 10;
    localparam int DIRPOL_DIR = 0;
    localparam int DIRPOL_POL = 1;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_ERR = 2;
    localparam int ST_STATE_LSB = 4;
    localparam int ACC_LSB = 0;
    localparam int DEC_LSB = 16;
    localparam int TIME_W = 16;
    localparam logic [3:0] METH_CRADLE = 4'h7;
    localparam logic [3:0] METH_FIRST_IDX = 4'h8;
    localparam logic [3:0] METH_FRONT = 4'h9;
    localparam logic [3:0] METH_DOGLESS = 4'ha;
    localparam logic [31:0] RST_WORD = 32'h0;
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_FAST = 3'h1,
        S_CREEP = 3'h3,
        S_LEAVE = 3'h2,
        S_SHIFT = 3'h6
    } hm_state_type;
endpackage : hm_pkg

// ---- design/hm_pos_track.sv ----
// Current position and travel counter
`timescale 1ns/1ps
`default_nettype none
module hm_pos_track #(
    parameter int POS_W = 32
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic enc_step,
    input wire logic enc_dir,
    input wire logic load,
    input wire logic [POS_W-1:0] load_value,
    input wire logic travel_clr,
    output var logic [POS_W-1:0] cur_pos,
    output var logic [POS_W-1:0] travel
);
    import hm_pkg::*;
    logic [POS_W-1:0] pos_reg, pos_next, trav_reg, trav_next;
    always_comb
    begin
        pos_next = pos_reg;
        if (load)
            pos_next = load_value;
        else if (enc_step)
            pos_next = enc_dir ? pos_reg - 1'b1 : pos_reg + 1'b1;
        trav_next = travel_clr ? '0 : (enc_step ? trav_reg + 1'b1 : trav_reg);
    end
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pos_reg <= '0;
            trav_reg <= '0;
        end
        else
        begin
            pos_reg <= pos_next;
            trav_reg <= trav_next;
        end
    end
    assign cur_pos = pos_reg;
    assign travel = trav_reg;
endmodule : hm_pos_track
`default_nettype wire

// ---- tb/hm_axis_model.sv ----
// Axis model: proximity dog sensor and encoder driven by the commanded motion
`timescale 1ns/1ps
`default_nettype none
module hm_axis_model #(
    parameter int DOG_LO = 10,
    parameter int DOG_HI = 20,
    parameter int IDX_EVERY = 16
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic motion_enable,
    input wire logic move_dir,
    input wire logic dog_high,
    output var logic dog_in,
    output var logic enc_index,
    output var logic enc_step,
    output var logic enc_dir
);
    int pos;
    int apos;
    logic tick;
    // One encoder count every second cycle while moving
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            pos <= 0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= motion_enable & ~tick;
            if (tick)
                pos <= move_dir ? pos - 1 : pos + 1;
        end
    end
    assign apos = (pos < 0) ? -pos : pos;
    assign enc_step = tick;
    assign enc_dir = move_dir;
    assign enc_index = ((pos % IDX_EVERY) == 0);
    // Dog level inverted when polarity is active low
    assign dog_in = (apos >= DOG_LO && apos <= DOG_HI) ? dog_high : ~dog_high;
endmodule : hm_axis_model
`default_nettype wire

// ---- tb/tb_dog_and_index_homing_sequencer.sv ----
// Self-checking bench of the homing sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_dog_and_index_homing_sequencer;
    import hm_pkg::*;
    localparam logic [31:0] FAST = 32'h40;
    localparam logic [31:0] CREEP = 32'h8;
    localparam logic [31:0] HOME = 32'h1234;
    localparam logic [31:0] ACCDEC = 32'h0055_0011;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] avs_address = 8'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, dog_in, enc_index, enc_step, enc_dir, motion_enable, move_dir, home_done;
    logic dog_high = 1'b1;
    logic [31:0] speed_cmd, cur_pos;
    logic [15:0] accel_time, decel_time;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 ref_clk = ~ref_clk;
    hm_homing dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dog_in(dog_in),
        .enc_index(enc_index), .enc_step(enc_step), .enc_dir(enc_dir), .motion_enable(motion_enable),
        .move_dir(move_dir), .speed_cmd(speed_cmd), .accel_time(accel_time), .decel_time(decel_time),
        .home_done(home_done), .cur_pos(cur_pos));
    hm_axis_model axis_u (.ref_clk(ref_clk), .rst(rst), .motion_enable(motion_enable), .move_dir(move_dir),
        .dog_high(dog_high), .dog_in(dog_in), .enc_index(enc_index), .enc_step(enc_step), .enc_dir(enc_dir));
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : give_verdict
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic av_wr(input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : av_wr
    task automatic av_rd(input logic [7:0] a, output logic [31:0] d);
        avs_address <= a;
        avs_read <= 1'b1;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        @(posedge ref_clk);
    endtask : av_rd
    task automatic do_reset(input logic pol);
        rst <= 1'b1;
        dog_high <= pol;
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
    endtask : do_reset
    task automatic setup(input logic [3:0] m, input logic [1:0] dp, input logic [31:0] sh);
        do_reset(dp[1]);
        av_wr(OFS_METHOD, {28'h0, m});
        av_wr(OFS_DIRPOL, {30'h0, dp});
        av_wr(OFS_FAST, FAST);
        av_wr(OFS_CREEP, CREEP);
        av_wr(OFS_SHIFT, sh);
        av_wr(OFS_HOME, HOME);
        av_wr(OFS_ACCDEC, ACCDEC);
        av_wr(OFS_CTRL, 32'h2);
        av_wr(OFS_CTRL, 32'h3);
        repeat (3) @(posedge ref_clk);
        chk("speed fast", FAST, speed_cmd);
        chk("start dir", {31'h0, dp[0]}, {31'h0, move_dir});
        chk("accel", ACCDEC[15:0], {16'h0, accel_time});
        chk("decel", ACCDEC[31:16], {16'h0, decel_time});
    endtask : setup
    task automatic wait_dog(input logic lvl);
        int k;
        k = 0;
        while (dog_in !== lvl && k < 500)
        begin
            @(posedge ref_clk);
            k++;
        end
        repeat (4) @(posedge ref_clk);
    endtask : wait_dog
    task automatic finish_home();
        int k;
        k = 0;
        while (home_done !== 1'b1 && k < 3000)
        begin
            @(posedge ref_clk);
            k++;
        end
        chk("home_done", 32'h1, {31'h0, home_done});
        chk("cur_pos", HOME, cur_pos);
        chk("stopped", 32'h0, {31'h0, motion_enable});
    endtask : finish_home
    task automatic test_regs();
        logic [31:0] d;
        do_reset(1'b1);
        av_rd(OFS_STATUS, d);
        chk("status reset", 32'h0, d);
        av_rd(8'h3c, d);
        chk("unmapped", 32'h0, d);
        av_wr(OFS_CTRL, 32'h402);
        av_rd(OFS_CTRL, d);
        chk("ctrl source bit", 32'h402, d);
        av_wr(OFS_CTRL, 32'h7);
        av_rd(OFS_STATUS, d);
        chk("refused start", 32'h4, d & 32'h7);
        // Good start, then abort by leaving manual mode
        av_wr(OFS_METHOD, {28'h0, METH_DOGLESS});
        av_wr(OFS_CTRL, 32'h3);
        chk("busy after start", 32'h1, {31'h0, motion_enable});
        av_wr(OFS_CTRL, 32'h0);
        av_rd(OFS_STATUS, d);
        chk("abort status", 32'h4, d & 32'h7);
        chk("abort stopped", 32'h0, {31'h0, motion_enable});
    endtask : test_regs
    task automatic test_cradle();
        setup(METH_CRADLE, 2'b10, 32'h2);
        wait_dog(1'b1);
        chk("creep after dog", CREEP, speed_cmd);
        finish_home();
    endtask : test_cradle
    task automatic test_first_index();
        setup(METH_FIRST_IDX, 2'b00, 32'h1);
        wait_dog(1'b0);
        chk("reversed", 32'h1, {31'h0, move_dir});
        chk("reverse creep", CREEP, speed_cmd);
        finish_home();
    endtask : test_first_index
    task automatic test_front();
        setup(METH_FRONT, 2'b10, 32'h0);
        finish_home();
    endtask : test_front
    task automatic test_dogless();
        setup(METH_DOGLESS, 2'b11, 32'h3);
        finish_home();
    endtask : test_dogless
    initial
    begin
        test_regs();
        test_cradle();
        test_first_index();
        test_front();
        test_dogless();
        give_verdict();
    end
endmodule : tb_dog_and_index_homing_sequencer
`default_nettype wire
